// >>> wdr_top.sv
// Purpose: Watchdog with two 16-bit and one 32-bit counter, forcing a system reset
// Assumes: Inputs synchronous to mclk_i; configuration held stable by firmware
// Notes: Counter 0 heads the cascade chain; counter 1 may follow 0, counter 2 may follow 1
`default_nettype none

module wdr_counter #(
   parameter int W = 16
) (
   input wire logic mclk_i,
   input wire logic nrst_i,
   input wire logic en_i,
   input wire logic casc_i,
   input wire logic prev_hit_i,
   input wire logic clr_i,
   input wire logic [W-1:0] match_i,
   output logic [W-1:0] cnt_o,
   output logic hit_o
);
   logic [W-1:0] cnt_reg;
   logic [W-1:0] cnt_next;
   wire logic advance;
   wire logic at_match;

   // A cascaded counter only steps on its predecessor's terminal event
   assign advance = en_i & (casc_i ? prev_hit_i : 1'b1);
   assign at_match = (cnt_reg == match_i);
   assign hit_o = advance & at_match;
   assign cnt_next = clr_i ? '0 : (hit_o ? '0 : (advance ? cnt_reg + W'(1) : cnt_reg));

   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         cnt_reg <= '0;
      else
         cnt_reg <= cnt_next;
   end

   assign cnt_o = cnt_reg;

   // Shared by all three counters, so one set of checks covers every instance
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!nrst_i);

   a_cnt_clear: assert property (clr_i |=> cnt_reg == '0)
      else $error("counter not zeroed by its clear");
   a_cnt_hold: assert property (!advance && !clr_i |=> $stable(cnt_reg))
      else $error("idle counter moved");
   a_cnt_step: assert property (advance && !at_match && !clr_i |=> cnt_reg == $past(cnt_reg) + W'(1))
      else $error("counter did not step by one");
   a_cnt_wrap: assert property (hit_o |=> cnt_reg == '0)
      else $error("counter did not wrap at its terminal count");
endmodule // wdr_counter

// What this block does
// - Provides two 16-bit counters and one 32-bit counter.
// - Counter 0 always runs alone; counters 1 and 2 run alone or stepped by the previous counter's terminal event.
// - Counter 0 raises an interrupt each time it reaches its terminal count.
// - Three consecutive unhandled counter 0 interrupts issue a system reset.
// - Reset follows the third unhandled interrupt, about 3.9 ms after servicing stops with the 0xFFFF terminal count.
// - The system reset restarts the processor from its entry point.
module wdr_top
   import wdr_pkg::*;
(
   // Clock and reset
   input wire logic mclk_i,
   input wire logic nrst_i,
   // Counter configuration
   input wire wdr_pkg::wdr_cfg16_t cfg0_i,
   input wire wdr_pkg::wdr_cfg16_t cfg1_i,
   input wire wdr_pkg::wdr_cfg32_t cfg2_i,
   // Firmware service strobes
   input wire logic clr0_i,
   input wire logic clr1_i,
   input wire logic clr2_i,
   // Counter state
   output logic [15:0] cnt0_o,
   output logic [15:0] cnt1_o,
   output logic [31:0] cnt2_o,
   // Interrupts and system reset
   output wdr_pkg::wdr_irq_t irq_o,
   output logic sys_rst_o
);
   import wdr_pkg::*;

   wire logic hit0;
   wire logic hit1;
   wire logic hit2;
   wire logic miss_done;
   wire logic pulse_on;
   logic [1:0] tally_reg;
   logic [1:0] tally_next;
   logic [2:0] pulse_reg;
   logic [2:0] pulse_next;
   wdr_irq_t irq_reg;
   wdr_irq_t irq_next;

   // Counter 0 has no predecessor, so its cascade bit is ignored
   wdr_counter #(.W(WDR_W16)) u_ctr0 (
      .mclk_i(mclk_i),
      .nrst_i(nrst_i),
      .en_i(cfg0_i.en),
      .casc_i(1'b0),
      .prev_hit_i(1'b0),
      .clr_i(clr0_i),
      .match_i(cfg0_i.match),
      .cnt_o(cnt0_o),
      .hit_o(hit0)
   );

   wdr_counter #(.W(WDR_W16)) u_ctr1 (
      .mclk_i(mclk_i),
      .nrst_i(nrst_i),
      .en_i(cfg1_i.en),
      .casc_i(cfg1_i.casc),
      .prev_hit_i(hit0),
      .clr_i(clr1_i),
      .match_i(cfg1_i.match),
      .cnt_o(cnt1_o),
      .hit_o(hit1)
   );

   wdr_counter #(.W(WDR_W32)) u_ctr2 (
      .mclk_i(mclk_i),
      .nrst_i(nrst_i),
      .en_i(cfg2_i.en),
      .casc_i(cfg2_i.casc),
      .prev_hit_i(hit1),
      .clr_i(clr2_i),
      .match_i(cfg2_i.match),
      .cnt_o(cnt2_o),
      .hit_o(hit2)
   );

   // Sticky flags: a terminal event in the clearing cycle still sets the flag
   assign irq_next.irq0 = hit0 | (irq_reg.irq0 & ~clr0_i);
   assign irq_next.irq1 = hit1 | (irq_reg.irq1 & ~clr1_i);
   assign irq_next.irq2 = hit2 | (irq_reg.irq2 & ~clr2_i);

   // Third unhandled terminal event fires the reset
   assign miss_done = hit0 & ~clr0_i & (tally_reg == WDR_MISS_LIMIT - 2'h1);
   // Clear restarts the tally, but a coincident terminal event still counts as one
   assign tally_next = miss_done ? WDR_TALLY_RST :
                       hit0 ? (clr0_i ? 2'h1 : tally_reg + 2'h1) :
                       clr0_i ? WDR_TALLY_RST : tally_reg;
   assign pulse_on = (pulse_reg != WDR_PULSE_RST);
   // Several cycles wide so the processor reset logic cannot miss it
   assign pulse_next = miss_done ? WDR_PULSE_LOAD : (pulse_on ? pulse_reg - 3'h1 : WDR_PULSE_RST);

   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         tally_reg <= WDR_TALLY_RST;
         pulse_reg <= WDR_PULSE_RST;
         irq_reg <= '0;
         sys_rst_o <= 1'b0;
      end
      else
      begin
         tally_reg <= tally_next;
         pulse_reg <= pulse_next;
         irq_reg <= irq_next;
         sys_rst_o <= (pulse_next != WDR_PULSE_RST);
      end
   end

   assign irq_o = irq_reg;

   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!nrst_i);

   a_ctr0_wrap: assert property (hit0 && !clr0_i |=> cnt0_o == 16'h0000)
      else $error("counter 0 did not wrap at terminal count");
   a_ctr1_cascade: assert property (cfg1_i.en && cfg1_i.casc && !hit0 && !clr1_i |=> $stable(cnt1_o))
      else $error("cascaded counter 1 moved without a counter 0 event");
   a_ctr2_step: assert property (cfg2_i.en && !cfg2_i.casc && !clr2_i && !hit2 |=> cnt2_o == $past(cnt2_o) + 32'h1)
      else $error("free counter 2 did not step");
   a_irq0_set: assert property (hit0 |=> irq_o.irq0)
      else $error("counter 0 interrupt not raised");
   a_third_miss: assert property (hit0 && !clr0_i && tally_reg == 2'h2 |=> sys_rst_o)
      else $error("third unhandled interrupt gave no reset");
   a_rst_cause: assert property ($rose(sys_rst_o) |-> $past(hit0) && $past(tally_reg) == 2'h2)
      else $error("system reset without three unhandled interrupts");
   a_rst_width: assert property ($rose(sys_rst_o) |-> sys_rst_o[*4] ##1 !sys_rst_o)
      else $error("system reset pulse width wrong");
   a_clr_tally: assert property (clr0_i && !hit0 |=> tally_reg == 2'h0 && cnt0_o == 16'h0000)
      else $error("clear did not restart tally and counter 0");

   // Counter stepping and holding as seen at the top
   a_ctr0_step: assert property (cfg0_i.en && !hit0 && !clr0_i |=> cnt0_o == $past(cnt0_o) + 16'h1)
      else $error("counter 0 did not step");
   a_ctr1_step: assert property (cfg1_i.en && cfg1_i.casc && hit0 && !hit1 && !clr1_i
      |=> cnt1_o == $past(cnt1_o) + 16'h1)
      else $error("cascaded counter 1 missed a step");
   a_ctr2_hold: assert property (cfg2_i.en && cfg2_i.casc && !hit1 && !clr2_i |=> $stable(cnt2_o))
      else $error("cascaded counter 2 moved without a counter 1 event");

   // Flags and tally; sys_rst_o mirrors pulse_reg, so a low output means no pulse pending
   a_irq0_hold: assert property (irq_o.irq0 && !clr0_i |=> irq_o.irq0)
      else $error("counter 0 interrupt dropped without a clear");
   a_irq0_clear: assert property (clr0_i && !hit0 |=> !irq_o.irq0)
      else $error("counter 0 interrupt not cleared");
   a_irq1_set: assert property (hit1 |=> irq_o.irq1)
      else $error("counter 1 interrupt not raised");
   a_irq1_clear: assert property (clr1_i && !hit1 |=> !irq_o.irq1)
      else $error("counter 1 interrupt not cleared");
   a_irq2_set: assert property (hit2 |=> irq_o.irq2)
      else $error("counter 2 interrupt not raised");
   a_tally_hit: assert property (hit0 && !clr0_i && tally_reg != 2'h2
      |=> tally_reg == $past(tally_reg) + 2'h1)
      else $error("unhandled interrupt not tallied");
   a_no_early_rst: assert property (!sys_rst_o && !(hit0 && !clr0_i && tally_reg == 2'h2) |=> !sys_rst_o)
      else $error("system reset before the third unhandled interrupt");

   c_reset_fired: cover property ($rose(sys_rst_o));
   c_clr_on_hit: cover property (clr0_i && hit0);
   c_cascade_hit: cover property (cfg1_i.casc && hit1);
   c_free_ctr2: cover property (cfg2_i.en && !cfg2_i.casc && cnt2_o == 32'h0000_FFFF);
   c_serviced_miss: cover property (clr0_i && tally_reg == 2'h1);
endmodule // wdr_top
`default_nettype wire

// >>> wdr_pkg.sv
// Purpose: Shared types and constants for the watchdog reset counter block
// Assumes: One 50 MHz clock, asynchronous active-low reset
// Notes: Counter configuration travels as packed structs
`default_nettype none
package wdr_pkg;
   // Counter widths
   localparam int WDR_W16 = 16;
   localparam int WDR_W32 = 32;
   // Clock rate and reset pulse
   localparam int WDR_CLK_HZ = 50_000_000;
   localparam int WDR_RST_PULSE_CYC = 4;
   // Unhandled interrupts that issue a system reset
   localparam logic [1:0] WDR_MISS_LIMIT = 2'h3;
   localparam logic [1:0] WDR_TALLY_RST = 2'h0;
   localparam logic [2:0] WDR_PULSE_RST = 3'h0;
   localparam logic [2:0] WDR_PULSE_LOAD = 3'(WDR_RST_PULSE_CYC);
   // Terminal count firmware is expected to use for counter 0
   localparam logic [15:0] WDR_TC_DEFAULT = 16'hFFFF;

   typedef struct packed {
      logic en;
      logic casc;
      logic [WDR_W16-1:0] match;
   } wdr_cfg16_t;

   typedef struct packed {
      logic en;
      logic casc;
      logic [WDR_W32-1:0] match;
   } wdr_cfg32_t;

   typedef struct packed {
      logic irq0;
      logic irq1;
      logic irq2;
   } wdr_irq_t;
endpackage
`default_nettype wire

// >>> wdr_fw_model.sv
// Purpose: Firmware model that services watchdog counter 0
// Assumes: Clears are launched just after a clock edge
// Notes: Service period is a plain parameter; clears stop while svc_i is low
`default_nettype none
module wdr_fw #(
   parameter int PER = 4
) (
   input wire logic mclk_i,
   input wire logic nrst_i,
   input wire logic svc_i,
   output logic clr0_o
);
   timeunit 1ns;
   timeprecision 1ps;
   int n = 0;
   always @(posedge mclk_i or negedge nrst_i)
   begin
      n <= (!nrst_i || n == PER - 1) ? 0 : n + 1;
      clr0_o <= #1 nrst_i && svc_i && n == PER - 1;
   end
endmodule // wdr_fw
`default_nettype wire

// >>> testbench.sv
// Purpose: Self-checking bench for the watchdog reset counter
// Assumes: Small terminal counts stand in for the slow watchdog timing
// Notes: Counter 0 is serviced by the firmware model only
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import wdr_pkg::*;
   logic mclk_i = 1'b0, nrst_i = 1'b0, svc = 1'b0, clr1 = 1'b0, clr2 = 1'b0, clr0, sys_rst;
   wdr_cfg16_t cfg0 = '0, cfg1 = '0;
   wdr_cfg32_t cfg2 = '0;
   logic [15:0] cnt0, cnt1;
   logic [31:0] cnt2;
   wdr_irq_t irq;
   int fail_count = 0, checked = 0, n;
   always #10 mclk_i = ~mclk_i;
   wdr_fw #(.PER(4)) fw (.mclk_i(mclk_i), .nrst_i(nrst_i), .svc_i(svc), .clr0_o(clr0));
   wdr_top uut (.mclk_i(mclk_i), .nrst_i(nrst_i), .cfg0_i(cfg0), .cfg1_i(cfg1), .cfg2_i(cfg2),
      .clr0_i(clr0), .clr1_i(clr1), .clr2_i(clr2), .cnt0_o(cnt0), .cnt1_o(cnt1), .cnt2_o(cnt2),
      .irq_o(irq), .sys_rst_o(sys_rst));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         fail_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wrap_up();
      $display("checks=%0d mismatches=%0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic rst();
      nrst_i = 1'b0;
      repeat (4) @(posedge mclk_i);
      #1 nrst_i = 1'b1;
   endtask
   // Bounded wait for the system reset; n ends as the edges waited
   task automatic wait_rst(input int lim);
      for (n = 0; n < lim && sys_rst !== 1'b1; n++)
         @(posedge mclk_i) #1;
      if (sys_rst !== 1'b1)
      begin
         fail_count++;
         wrap_up();
      end
   endtask
   task automatic t_miss();
      rst();
      cfg0 = '{1'b1, 1'b0, 16'h0002};
      wait_rst(20);
      chk(n, 32'h9);
      chk(irq.irq0, 32'h1);
      chk(cnt0, 32'h0);
      repeat (3) @(posedge mclk_i) #1;
      chk(sys_rst, 32'h1);
      @(posedge mclk_i) #1;
      chk(sys_rst, 32'h0);
      @(posedge mclk_i) #1;
      $display("t_miss done");
   endtask
   task automatic t_svc();
      rst();
      cfg0 = '{1'b1, 1'b0, 16'h0002};
      svc = 1'b1;
      repeat (40)
      begin
         @(posedge mclk_i) #1;
         chk(sys_rst, 32'h0);
      end
      // Servicing stops: reset must follow the third miss
      svc = 1'b0;
      wait_rst(20);
      chk(n, 32'hA);
      $display("t_svc done");
   endtask
   task automatic t_casc();
      rst();
      cfg0 = '{1'b1, 1'b0, 16'h0001};
      cfg1 = '{1'b1, 1'b1, 16'h0001};
      cfg2 = '{1'b1, 1'b1, 32'h0000_0000};
      repeat (3) @(posedge mclk_i) #1;
      chk(cnt1, 32'h1);
      chk(irq.irq1, 32'h0);
      @(posedge mclk_i) #1;
      chk({irq.irq1, irq.irq2}, 32'h3);
      chk(cnt2, 32'h0);
      clr1 = 1'b1;
      clr2 = 1'b1;
      @(posedge mclk_i) #1;
      clr1 = 1'b0;
      clr2 = 1'b0;
      chk({irq.irq1, irq.irq2}, 32'h0);
      $display("t_casc done");
   endtask
   // Full terminal count: the first interrupt needs 0x10000 counting edges
   task automatic t_tc();
      rst();
      cfg0 = '{1'b1, 1'b0, WDR_TC_DEFAULT};
      cfg2 = '{1'b1, 1'b0, 32'hFFFF_FFFF};
      for (n = 0; n < 70000 && irq.irq0 !== 1'b1; n++)
         @(posedge mclk_i) #1;
      chk(n, 32'h0001_0000);
      chk(cnt0, 32'h0);
      chk(cnt2, 32'h0001_0000);
      $display("t_tc done");
   endtask
   initial
   begin
      t_miss();
      t_svc();
      t_casc();
      t_tc();
      wrap_up();
   end
endmodule // testbench
`default_nettype wire
